// file: core/wdg_pkg.sv
// constants, types and register map of the dual stage watchdog
// How it works
// - Two separately programmed stages run in turn, and the second starts when the first expires, or at once if the first is off.
// - A stage whose action is none is off, and the sequence passes over it at once.
// - A stage with the reset action pulses a module restart request when it expires.
// - A stage with the NMI action pulses a non-maskable interrupt request when it expires.
// - A stage with the SMI action pulses a system management interrupt request when it expires.
// - A stage with the SCI action pulses an OS-visible control interrupt request when it expires.
// - The delay action exists only for stage one and only stretches the time before stage two, after the enable and again after every trigger.
// - The pin-only action asserts the alarm pin and issues no restart and no interrupt.
// - The alarm pin is asserted when the configuration-selected stage times out without a trigger in time and its action has the pin bit.
// - A configuration bit picks whether stage one or stage two may raise the alarm pin.
// - The alarm pin falls only on reset; nothing at run time clears it.
package wdg_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_ACT1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ACT2 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_TIME1 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_TIME2 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_TRIG = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h1C;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PINSTAGE_BIT = 1;
  localparam int STAT_PIN_BIT = 4;
  localparam int STAT_DONE_BIT = 5;
  localparam int ACT_PIN_BIT = 3;
  localparam logic [31:0] TIME_RESET = 32'h0000_FFFF;

  // action codes: bit 3 adds the alarm pin, bits 2:0 the base action
  typedef logic [3:0] wdg_act_t;
  localparam wdg_act_t ACT_NONE = 4'h0;
  localparam wdg_act_t ACT_RESET = 4'h1;
  localparam wdg_act_t ACT_NMI = 4'h2;
  localparam wdg_act_t ACT_SMI = 4'h3;
  localparam wdg_act_t ACT_SCI = 4'h4;
  localparam wdg_act_t ACT_DELAY = 4'h5;
  localparam wdg_act_t ACT_PIN_ONLY = 4'h8;
  localparam wdg_act_t ACT_RESET_PIN = 4'h9;
  localparam wdg_act_t ACT_NMI_PIN = 4'hA;
  localparam wdg_act_t ACT_SMI_PIN = 4'hB;
  localparam wdg_act_t ACT_SCI_PIN = 4'hC;
  localparam wdg_act_t ACT_DELAY_PIN = 4'hD;

  // timing: timeouts count in ticks of one microsecond
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_STAGE1 = 4'h2,
    ST_STAGE2 = 4'h4,
    ST_DONE = 4'h8
  } wdg_state_t;

  typedef struct packed {
    logic restart;
    logic nmi;
    logic smi;
    logic sci;
  } wdg_evt_t;
endpackage : wdg_pkg

// file: core/wdg_dual_stage.sv
// dual stage watchdog with apb register access and alarm pin
module wdg_dual_stage import wdg_pkg::*; (
  input wire logic sys_clk, // 100 MHz system clock
  input wire logic resetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready, zero wait
  output logic pslverr, // apb error on unmapped address
  output wdg_evt_t actionReq, // one-cycle restart and interrupt requests
  output logic watchdog_alarm_pin // alarm toward the carrier, active high
);

  typedef struct packed {
    wdg_state_t st;
    logic en;
    logic pinStage;
    wdg_act_t act1;
    wdg_act_t act2;
    logic [31:0] time1;
    logic [31:0] time2;
    logic [31:0] cnt;
    logic [6:0] div;
    logic pin;
    wdg_evt_t evt;
    logic [31:0] rdata;
    logic slverr;
  } wdg_regs_t;

  wdg_regs_t q, n;
  logic wrAcc;
  logic setup;
  logic tick;
  logic expire;
  logic startReq;
  wdg_act_t expAct;

  function automatic logic actIsNone(input wdg_act_t a);
    actIsNone = (a == ACT_NONE);
  endfunction : actIsNone

  // unknown codes fold to none; delay is refused in stage two
  function automatic wdg_act_t actLegal(input wdg_act_t a, input logic second);
    wdg_act_t r;
    r = a;
    if (a[2:0] > ACT_DELAY[2:0]) begin
      r = ACT_NONE;
    end else if (second && a[2:0] == ACT_DELAY[2:0]) begin
      r = {a[ACT_PIN_BIT], 3'h0};
    end
    actLegal = r;
  endfunction : actLegal

  always_comb begin
    n = q;
    n.evt = '0;
    wrAcc = psel && penable && pwrite;
    setup = psel && !penable;
    tick = (q.div == TICK_LAST);
    expire = 1'b0;
    expAct = (q.st == ST_STAGE2) ? q.act2 : q.act1;
    startReq = 1'b0;

    // register writes take effect in the access phase
    if (wrAcc) begin
      case (paddr)
        OFF_CTRL: begin
          n.en = pwdata[CTRL_EN_BIT];
          n.pinStage = pwdata[CTRL_PINSTAGE_BIT];
          startReq = pwdata[CTRL_EN_BIT] && !q.en;
        end
        OFF_ACT1: n.act1 = actLegal(pwdata[3:0], 1'b0);
        OFF_ACT2: n.act2 = actLegal(pwdata[3:0], 1'b1);
        OFF_TIME1: n.time1 = pwdata;
        OFF_TIME2: n.time2 = pwdata;
        OFF_TRIG: startReq = q.en;
        default: begin
        end
      endcase
    end

    // stage timing
    case (q.st)
      ST_IDLE: begin
      end
      ST_STAGE1, ST_STAGE2: begin
        n.div = tick ? 7'h00 : q.div + 7'h01;
        if (tick) begin
          if (q.cnt == 32'h0000_0000) begin
            expire = 1'b1;
          end else begin
            n.cnt = q.cnt - 32'h0000_0001;
          end
        end
      end
      ST_DONE: begin
      end
      default: n.st = ST_IDLE;
    endcase

    if (expire) begin
      case (expAct[2:0])
        ACT_RESET[2:0]: n.evt.restart = 1'b1;
        ACT_NMI[2:0]: n.evt.nmi = 1'b1;
        ACT_SMI[2:0]: n.evt.smi = 1'b1;
        ACT_SCI[2:0]: n.evt.sci = 1'b1;
        default: begin
          // delay and pin-only fire no request
        end
      endcase
      // the pin is raised only by the stage that configuration selects
      if (expAct[ACT_PIN_BIT] && (q.pinStage == (q.st == ST_STAGE2))) begin
        n.pin = 1'b1;
      end
      if (q.st == ST_STAGE1 && !actIsNone(q.act2)) begin
        n.st = ST_STAGE2;
        n.cnt = q.time2;
        n.div = 7'h00;
      end else begin
        n.st = ST_DONE;
      end
    end

    // a trigger or enable restarts at stage one, skipping stages that are off
    if (startReq) begin
      n.div = 7'h00;
      if (!actIsNone(q.act1)) begin
        n.st = ST_STAGE1;
        n.cnt = q.time1;
      end else if (!actIsNone(q.act2)) begin
        n.st = ST_STAGE2;
        n.cnt = q.time2;
      end else begin
        n.st = ST_DONE;
      end
    end
    if (!n.en) begin
      n.st = ST_IDLE;
      n.div = 7'h00;
    end

    // read data is captured in the setup phase so prdata comes from a flop
    if (setup) begin
      n.slverr = 1'b0;
      n.rdata = 32'h0000_0000;
      case (paddr)
        OFF_CTRL: begin
          n.rdata[CTRL_EN_BIT] = q.en;
          n.rdata[CTRL_PINSTAGE_BIT] = q.pinStage;
        end
        OFF_ACT1: n.rdata[3:0] = q.act1;
        OFF_ACT2: n.rdata[3:0] = q.act2;
        OFF_TIME1: n.rdata = q.time1;
        OFF_TIME2: n.rdata = q.time2;
        OFF_TRIG: begin
        end
        OFF_STAT: begin
          n.rdata[3:0] = q.st;
          n.rdata[STAT_PIN_BIT] = q.pin;
          n.rdata[STAT_DONE_BIT] = (q.st == ST_DONE);
        end
        OFF_COUNT: n.rdata = q.cnt;
        default: n.slverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q.st <= ST_IDLE;
      q.en <= 1'b0;
      q.pinStage <= 1'b0;
      q.act1 <= ACT_NONE;
      q.act2 <= ACT_NONE;
      q.time1 <= TIME_RESET;
      q.time2 <= TIME_RESET;
      q.cnt <= 32'h0000_0000;
      q.div <= 7'h00;
      q.pin <= 1'b0;
      q.evt <= '0;
      q.rdata <= 32'h0000_0000;
      q.slverr <= 1'b0;
    end else begin
      q <= n;
    end
  end

  // zero wait states: the read word was latched during setup
  assign pready = 1'b1;
  assign prdata = q.rdata;
  assign pslverr = q.slverr;
  assign actionReq = q.evt;
  assign watchdog_alarm_pin = q.pin;

  // checks on the state record; inS1 and inS2 only rename states
  logic inS1, inS2;
  assign inS1 = (q.st == ST_STAGE1);
  assign inS2 = (q.st == ST_STAGE2);

  a_stage_skip: assert property (@(posedge sys_clk) disable iff (!resetn)
    (inS1 |-> !actIsNone(q.act1)) and (inS2 |-> !actIsNone(q.act2)))
    else $error("a disabled stage is running");

  a_stage_order: assert property (@(posedge sys_clk) disable iff (!resetn)
    ($rose(inS2) && !$past(startReq)) |-> $past(inS1 && expire))
    else $error("stage two started without stage one expiring");

  a_restart_cause: assert property (@(posedge sys_clk) disable iff (!resetn)
    (expire && expAct[2:0] == ACT_RESET[2:0]) |=> (actionReq.restart ##1 !actionReq.restart))
    else $error("reset action gave no single restart pulse");

  a_nmi_cause: assert property (@(posedge sys_clk) disable iff (!resetn)
    actionReq.nmi |-> $past(expire && expAct[2:0] == ACT_NMI[2:0]))
    else $error("nmi request without nmi stage expiry");

  a_smi_cause: assert property (@(posedge sys_clk) disable iff (!resetn)
    (expire && expAct[2:0] == ACT_SMI[2:0]) |=> actionReq.smi && !actionReq.nmi)
    else $error("smi action did not raise smi alone");

  a_sci_cause: assert property (@(posedge sys_clk) disable iff (!resetn)
    actionReq.sci |-> $past(expire && expAct[2:0] == ACT_SCI[2:0]))
    else $error("sci request without sci stage expiry");

  a_delay_first: assert property (@(posedge sys_clk) disable iff (!resetn)
    q.act2[2:0] != ACT_DELAY[2:0])
    else $error("delay action held by stage two");

  a_pin_only: assert property (@(posedge sys_clk) disable iff (!resetn)
    (expire && expAct == ACT_PIN_ONLY) |=> (actionReq == '0))
    else $error("pin-only action raised a request");

  a_pin_stage: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(watchdog_alarm_pin) |->
      $past(expire && expAct[ACT_PIN_BIT] && (q.pinStage == inS2)))
    else $error("alarm pin raised by the wrong stage");

  a_pin_fires: assert property (@(posedge sys_clk) disable iff (!resetn)
    (expire && expAct[ACT_PIN_BIT] && (q.pinStage == inS2)) |=> watchdog_alarm_pin)
    else $error("selected stage expired without alarm pin");

  a_pin_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
    watchdog_alarm_pin |=> watchdog_alarm_pin [*3])
    else $error("alarm pin cleared without reset");

  a_combo_both: assert property (@(posedge sys_clk) disable iff (!resetn)
    (expire && expAct == ACT_NMI_PIN && !q.pinStage && inS1) |=>
      (actionReq.nmi && watchdog_alarm_pin))
    else $error("combined action missed a part");

  a_trigger_restart: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wrAcc && paddr == OFF_TRIG && q.en && !actIsNone(q.act1)) |=>
      (inS1 && q.cnt == $past(q.time1)))
    else $error("trigger did not restart stage one");

  a_tick_period: assert property (@(posedge sys_clk) disable iff (!resetn)
    (tick && (inS1 || inS2) && !startReq && n.en) |=> (q.div == 7'h00))
    else $error("tick divider did not wrap");

  // requests are single-cycle pulses: a host that polls instead of latching misses them
  a_evt_single: assert property (@(posedge sys_clk) disable iff (!resetn)
    $onehot0(actionReq))
    else $error("more than one request at once");

  a_evt_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
    (actionReq != '0) |=> (actionReq == '0))
    else $error("request held longer than one cycle");

  a_idle_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
    (q.st == ST_IDLE || q.st == ST_DONE) |=> (actionReq == '0))
    else $error("request while no stage runs");

  a_restart_only: assert property (@(posedge sys_clk) disable iff (!resetn)
    actionReq.restart |-> $past(expire && expAct[2:0] == ACT_RESET[2:0]))
    else $error("restart request without reset stage expiry");

  a_nmi_fires: assert property (@(posedge sys_clk) disable iff (!resetn)
    (expire && expAct[2:0] == ACT_NMI[2:0]) |=>
      (actionReq.nmi && !actionReq.smi && !actionReq.sci))
    else $error("nmi action did not raise nmi alone");

  a_smi_only: assert property (@(posedge sys_clk) disable iff (!resetn)
    actionReq.smi |-> $past(expire && expAct[2:0] == ACT_SMI[2:0]))
    else $error("smi request without smi stage expiry");

  a_sci_alone: assert property (@(posedge sys_clk) disable iff (!resetn)
    (expire && expAct[2:0] == ACT_SCI[2:0]) |=>
      (actionReq.sci && !actionReq.restart && !actionReq.nmi))
    else $error("sci action did not raise sci alone");

  a_delay_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
    (expire && expAct[2:0] == ACT_DELAY[2:0]) |=> (actionReq == '0))
    else $error("delay action raised a request");

  a_pin_other: assert property (@(posedge sys_clk) disable iff (!resetn)
    (expire && (q.pinStage != inS2) && !watchdog_alarm_pin) |=> !watchdog_alarm_pin)
    else $error("alarm pin raised by the unselected stage");

  a_stage2_load: assert property (@(posedge sys_clk) disable iff (!resetn)
    (expire && inS1 && !actIsNone(q.act2) && !startReq && n.en) |=>
      (inS2 && q.cnt == $past(q.time2)))
    else $error("stage two did not load its time");

  a_last_done: assert property (@(posedge sys_clk) disable iff (!resetn)
    (expire && (inS2 || actIsNone(q.act2)) && !startReq && n.en) |=> (q.st == ST_DONE))
    else $error("last stage expiry did not end the sequence");

  // done is left only by a trigger or a disable; the restart request alone does not reset us
  a_done_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
    (q.st == ST_DONE && !startReq && n.en) |=> (q.st == ST_DONE))
    else $error("finished sequence left done on its own");

  a_trig_ignored: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wrAcc && paddr == OFF_TRIG && !q.en) |=> (q.st == ST_IDLE))
    else $error("trigger started a disabled watchdog");

  a_disable_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wrAcc && paddr == OFF_CTRL && !pwdata[CTRL_EN_BIT]) |=> (q.st == ST_IDLE))
    else $error("clearing enable did not stop the stages");

  a_cnt_falls: assert property (@(posedge sys_clk) disable iff (!resetn)
    ((inS1 || inS2) && tick && q.cnt != 32'h0000_0000 && !startReq && n.en) |=>
      (q.cnt == $past(q.cnt) - 32'h0000_0001))
    else $error("stage count did not fall by one per tick");

  a_div_range: assert property (@(posedge sys_clk) disable iff (!resetn)
    q.div <= TICK_LAST)
    else $error("tick divider ran past its last count");

  c_stage2_run: cover property (@(posedge sys_clk) disable iff (!resetn)
    inS1 && expire ##1 inS2);
  c_restart: cover property (@(posedge sys_clk) disable iff (!resetn)
    actionReq.restart);
  c_pin_raise: cover property (@(posedge sys_clk) disable iff (!resetn)
    $rose(watchdog_alarm_pin));
  c_retrigger: cover property (@(posedge sys_clk) disable iff (!resetn)
    inS2 && wrAcc && paddr == OFF_TRIG);
  c_delay_run: cover property (@(posedge sys_clk) disable iff (!resetn)
    inS1 && expire && expAct[2:0] == ACT_DELAY[2:0]);

endmodule : wdg_dual_stage

// file: testbench/wdg_host_carrier_model.sv
// host and carrier side model: logs watchdog requests and the alarm pin
module wdg_host_carrier_model import wdg_pkg::*; (
  input wire logic sys_clk, // system clock
  input wire wdg_evt_t actionReq, // restart and interrupt requests
  input wire logic watchdog_alarm_pin, // alarm pin toward the carrier
  input wire logic [31:0] cycNow // running cycle count of the bench
);
  timeunit 1ns;
  timeprecision 1ps;
  int evq[$];
  int pinAt = -1;
  task automatic clear();
    evq.delete();
    pinAt = -1;
  endtask : clear
  // sampled mid-cycle so each one-cycle request is logged exactly once
  always @(negedge sys_clk) begin
    if (actionReq !== 4'h0) begin
      evq.push_back(int'(cycNow) * 16 + int'(actionReq));
    end
    if (watchdog_alarm_pin === 1'b1 && pinAt < 0) begin
      pinAt = int'(cycNow);
    end
  end
endmodule : wdg_host_carrier_model

// file: testbench/tb.sv
// self-checking bench of the dual stage watchdog
module tb import wdg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin;
  wdg_evt_t actionReq;
  logic [31:0] cyc = '0;
  int err_total = 0;
  int n_checks = 0;
  int lastEdge = 0;
  logic [31:0] r;
  logic e;
  logic [3:0] codes[11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'h6};

  wdg_dual_stage wdg_dual_stage_i (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .actionReq(actionReq), .watchdog_alarm_pin(pin));
  wdg_host_carrier_model wdg_host_carrier_model_i (.sys_clk(sys_clk), .actionReq(actionReq),
    .watchdog_alarm_pin(pin), .cycNow(cyc));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 32'h1;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask : chk

  // one apb transfer; write lands and read data is taken at the ready edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    // no limit here: a slave that never answers is caught by the watchdog process
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    er = pslverr;
    if (w) lastEdge = int'(cyc) + 1;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never drives psel twice in one time step
    @(posedge sys_clk);
  endtask : xfer

  function automatic logic [3:0] fix(input logic [3:0] c, input logic st2);
    if (c[2:0] > 3'h5) return 4'h0;
    if (st2 && c[2:0] == 3'h5) return c & 4'h8;
    return c;
  endfunction : fix

  function automatic int evtOf(input logic [3:0] c);
    case (c[2:0])
      3'h1: return 8;
      3'h2: return 4;
      3'h3: return 2;
      3'h4: return 1;
      default: return 0;
    endcase
  endfunction : evtOf

  task automatic scen(input logic [3:0] a1, a2, input int t1, t2, input logic ps, input int trg);
    int eq[$];
    int t;
    int pe;
    int d;
    int pa;
    logic [3:0] s1;
    logic [3:0] s2;
    s1 = fix(a1, 1'b0);
    s2 = fix(a2, 1'b1);
    t = 0;
    pe = -1;
    if (s1 != 4'h0) begin
      t = (t1 + 1) * 100;
      if (evtOf(s1) != 0) eq.push_back(t * 16 + evtOf(s1));
      if (!ps && s1[3]) pe = t;
    end
    if (s2 != 4'h0) begin
      t = t + (t2 + 1) * 100;
      if (evtOf(s2) != 0) eq.push_back(t * 16 + evtOf(s2));
      if (ps && s2[3]) pe = t;
    end
    resetn <= 1'b0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    wdg_host_carrier_model_i.clear();
    xfer(1'b1, OFF_ACT1, {28'h0, a1}, r, e);
    xfer(1'b1, OFF_ACT2, {28'h0, a2}, r, e);
    xfer(1'b1, OFF_TIME1, 32'(t1), r, e);
    xfer(1'b1, OFF_TIME2, 32'(t2), r, e);
    xfer(1'b1, OFF_CTRL, {30'h0, ps, 1'b1}, r, e);
    d = lastEdge;
    if (trg > 0) begin
      repeat (trg) @(posedge sys_clk);
      xfer(1'b1, OFF_TRIG, 32'h1, r, e);
      d = lastEdge;
    end
    repeat (900) @(posedge sys_clk);
    chk(wdg_host_carrier_model_i.evq.size() == eq.size(), "event count");
    foreach (eq[i]) begin
      if (i < wdg_host_carrier_model_i.evq.size()) begin
        chk(wdg_host_carrier_model_i.evq[i] - d * 16 == eq[i], "event time or kind");
      end
    end
    pa = wdg_host_carrier_model_i.pinAt;
    chk((pa < 0 ? -1 : pa - d) == pe, "alarm pin time");
    chk(pin === (pe >= 0), "alarm pin held");
    xfer(1'b0, OFF_STAT, 32'h0, r, e);
    chk(r[5:0] === ((pe >= 0) ? 6'h38 : 6'h28), "status after run");
    $display("test act1=%h act2=%h stage=%b done", a1, a2, ps);
  endtask : scen

  initial begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    wrap_up();
  end

  initial begin
    void'($urandom(49105));
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    xfer(1'b0, OFF_TIME1, 32'h0, r, e);
    chk(r === TIME_RESET && e === 1'b0, "time reset value");
    xfer(1'b0, OFF_STAT, 32'h0, r, e);
    chk(r[4:0] === 5'h01, "idle and pin low after reset");
    xfer(1'b0, 8'h20, 32'h0, r, e);
    chk(e === 1'b1 && r === 32'h0, "unmapped read");
    $display("test reset values done");
    foreach (codes[i]) begin
      scen(codes[i], 4'h0, $urandom % 4, 0, 1'b0, 0);
    end
    scen(4'h5, 4'h2, $urandom % 4, $urandom % 4, 1'b0, 0);
    scen(4'h0, 4'h3, 0, 1, 1'b0, 0);
    scen(4'h2, 4'h5, 1, 0, 1'b0, 0);
    scen(4'hA, 4'h9, 0, 2, 1'b1, 0);
    scen(4'h2, 4'hD, 1, 1, 1'b1, 0);
    scen(4'h3, 4'h0, 1, 0, 1'b0, 150);
    wrap_up();
  end
endmodule : tb
